// File: rtl/multi_mode_timer_unit.sv
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
// Operation
// [RULE1] Four 8-bit timers, prescaler then down counter, on separate timer clock.
// [RULE2] A and B: delay, pulse width, event count; C and D delay only.
// [RULE3] Delay mode: prescaler always runs; each count pulse decrements counter.
// [RULE4] Count pulse at 01 reloads from data register and emits timeout.
// [RULE5] Timeout goes to its interrupt channel; interrupts only when enabled.
// [RULE6] Each timeout toggles the timer output, held until next timeout.
// [RULE7] Prescale change mid-run: first timeout within 1..200 clocks, then correct.
// [RULE8] Load 01 times out every pulse; load 00 every 256 pulses.
// [RULE9] Pulse/event modes: line four/three channels follow aux inputs A/B.
// [RULE10] Pulse width mode: aux input active gates prescaler and counter.
// [RULE11] Edge bit 4 sets aux A active level, bit 3 aux B; one high.
// [RULE12] Pulse width mode: aux interrupt on opposite transition, marking pulse end.
// [RULE13] Data write after aux active: new value loads only when passing 01.
// [RULE14] Software rewrites data register after reading count, before next pulse.
// [RULE15] Leaving pulse mode restores polarity; mode or edge change may interrupt.
// [RULE16] Event count: prescaler bypassed, each active aux transition counts once.
// [RULE17] Event count through 01: timeout, toggle, interrupt option, reload.
// [RULE18] Aux input changes at most once every four timer clocks.
// [RULE19] Event count: edge bit one counts rising, zero falling; change may count.
// [RULE20] Event count: active aux transition also interrupts line channel if enabled.
// [RULE21] Port line interrupts on falling edge for bit zero, rising for one.
// [RULE22] Edges found by XOR of edge bit and input; configure before enabling.
// [RULE23] Data write to stopped timer loads counter too; running loads at 01.
// [RULE24] Mode field: stopped, delay with seven prescales, event, pulse width.
// [RULE25] Stopped timer keeps counter but discards prescaler residue.
// [RULE26] Timeout is one timer clock wide, recorded once as pending event.
module multi_mode_timer_unit
  import timer_unit_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        timer_clk,
  input  wire logic        aux_input_a,
  input  wire logic        aux_input_b,
  input  wire logic        port_line_three,
  input  wire logic        port_line_four,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             timer_a_output,
  output logic             timer_b_output,
  output logic             timer_c_output,
  output logic             timer_d_output,
  output logic             irq_pending_any
);

  // Timer clock is sampled as a plain input: no edge before its own sync pair
  typedef struct packed {
    logic [1:0]  tclk_sync;
    logic        tclk_prev;
    logic        w_strb_bad;
    logic [1:0]  aux_a_sync;
    logic [1:0]  aux_b_sync;
    logic [1:0]  line3_sync;
    logic [1:0]  line4_sync;
    logic        det_a_prev;
    logic        det_b_prev;
    logic        det_3_prev;
    logic        det_4_prev;
    logic        ev_a_prev;
    logic        ev_b_prev;
    logic [7:0]  edge_select_ff;
    logic [3:0]  ctrl_a;
    logic [3:0]  ctrl_b;
    logic [2:0]  ctrl_c;
    logic [2:0]  ctrl_d;
    logic [31:0] data_q;
    logic [31:0] count_q;
    logic [31:0] pre_q;
    logic [3:0]  reload_pend;
    logic [3:0]  out_q;
    logic [3:0]  out_hold;
    logic [5:0]  irq_en;
    logic [5:0]  irq_pend;
    bus_state_t  wr_st;
    bus_state_t  rd_st;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        w_err;
    logic [31:0] rdata;
    logic        r_err;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;

  function automatic logic [7:0] prescale(input logic [2:0] sel);
    unique case (sel)
      3'd1:    prescale = PRE_DIV4;
      3'd2:    prescale = PRE_DIV10;
      3'd3:    prescale = PRE_DIV16;
      3'd4:    prescale = PRE_DIV50;
      3'd5:    prescale = PRE_DIV64;
      3'd6:    prescale = PRE_DIV100;
      3'd7:    prescale = PRE_DIV200;
      default: prescale = PRE_DIV4;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_EDGE_SELECT) || (a == ADDR_CTRL_A) || (a == ADDR_CTRL_B) ||
             (a == ADDR_CTRL_CD) || (a == ADDR_DATA_A) || (a == ADDR_DATA_B) ||
             (a == ADDR_DATA_C) || (a == ADDR_DATA_D) || (a == ADDR_IRQ_ENABLE) ||
             (a == ADDR_IRQ_PENDING) || (a == ADDR_OUT_STATUS);
  endfunction

  logic        tick;
  logic        wr_fire;
  logic [3:0]  mode [4];
  logic [3:0]  pulse_mode;
  logic [3:0]  event_mode;
  logic [3:0]  running;
  logic [3:0]  cnt_pulse;
  logic [3:0]  timeout;
  logic [3:0]  data_wr;
  logic [5:0]  ev_in;
  logic        det_a;
  logic        det_b;
  logic        det_3;
  logic        det_4;
  logic        ch3_det;
  logic        ch4_det;
  logic [7:0]  cnt_i;
  logic [7:0]  pre_i;
  logic [7:0]  wd;

  always_comb begin
    nxt_cur = cur_ff;
    wd = cur_ff.w_data[7:0];
    cnt_i = 8'h00;
    pre_i = 8'h00;
    nxt_cur.tclk_sync = {cur_ff.tclk_sync[0], timer_clk};
    nxt_cur.aux_a_sync = {cur_ff.aux_a_sync[0], aux_input_a};
    nxt_cur.aux_b_sync = {cur_ff.aux_b_sync[0], aux_input_b};
    nxt_cur.line3_sync = {cur_ff.line3_sync[0], port_line_three};
    nxt_cur.line4_sync = {cur_ff.line4_sync[0], port_line_four};
    nxt_cur.tclk_prev = cur_ff.tclk_sync[1];
    // All timer logic advances on rising timer clock edges only
    tick = cur_ff.tclk_sync[1] & ~cur_ff.tclk_prev; // see [RULE1]
    mode[0] = cur_ff.ctrl_a;
    mode[1] = cur_ff.ctrl_b;
    mode[2] = {1'b0, cur_ff.ctrl_c}; // see [RULE2]
    mode[3] = {1'b0, cur_ff.ctrl_d};
    // XNOR detectors: output high means input is in its active state
    det_a = cur_ff.aux_a_sync[1] ~^ cur_ff.edge_select_ff[EDGE_BIT_A]; // see [RULE11] [RULE22]
    det_b = cur_ff.aux_b_sync[1] ~^ cur_ff.edge_select_ff[EDGE_BIT_B];
    det_3 = cur_ff.line3_sync[1] ~^ cur_ff.edge_select_ff[EDGE_BIT_B];
    det_4 = cur_ff.line4_sync[1] ~^ cur_ff.edge_select_ff[EDGE_BIT_A];
    for (int i = 0; i < 4; i++) begin
      pulse_mode[i] = mode[i][MODE_PULSE_BIT] && (mode[i] != MODE_EVENT);
      event_mode[i] = (mode[i] == MODE_EVENT); // see [RULE24]
    end
    // Counting gates sampled per timer clock; rule on four-clock spacing keeps this safe
    running[0] = (mode[0] != MODE_STOP) && (!pulse_mode[0] || det_a); // see [RULE10]
    running[1] = (mode[1] != MODE_STOP) && (!pulse_mode[1] || det_b);
    running[2] = (mode[2] != MODE_STOP);
    running[3] = (mode[3] != MODE_STOP);
    nxt_cur.ev_a_prev = tick ? det_a : cur_ff.ev_a_prev;
    nxt_cur.ev_b_prev = tick ? det_b : cur_ff.ev_b_prev;
    // Event pulse on inactive-to-active detector change, edge bit rewrite included
    ev_in[0] = tick && det_a && !cur_ff.ev_a_prev; // see [RULE16] [RULE18] [RULE19]
    ev_in[1] = tick && det_b && !cur_ff.ev_b_prev;
    ev_in[5:2] = 4'h0;
    wr_fire = cur_ff.aw_got && cur_ff.w_got && (cur_ff.wr_st == BUS_IDLE);
    data_wr = 4'h0;
    if (wr_fire) begin
      data_wr[0] = cur_ff.aw_addr == ADDR_DATA_A;
      data_wr[1] = cur_ff.aw_addr == ADDR_DATA_B;
      data_wr[2] = cur_ff.aw_addr == ADDR_DATA_C;
      data_wr[3] = cur_ff.aw_addr == ADDR_DATA_D;
    end
    cnt_pulse = 4'h0;
    timeout = 4'h0;
    for (int i = 0; i < 4; i++) begin
      cnt_i = cur_ff.count_q[8*i +: 8];
      pre_i = cur_ff.pre_q[8*i +: 8];
      if (mode[i] == MODE_STOP) begin
        pre_i = 8'h00; // see [RULE25]
      end else if (event_mode[i]) begin
        pre_i = 8'h00;
        cnt_pulse[i] = ev_in[i]; // see [RULE16]
      end else if (tick && running[i]) begin
        // Residue above a new smaller limit ends the prescale on the next tick: first timeout off by up to 200
        if (pre_i + 8'h01 >= prescale(mode[i][2:0])) begin // see [RULE3] [RULE7]
          pre_i = 8'h00;
          cnt_pulse[i] = 1'b1;
        end else begin
          pre_i = pre_i + 8'h01;
        end
      end
      if (cnt_pulse[i]) begin
        if (cnt_i == CNT_ONE) begin
          cnt_i = cur_ff.data_q[8*i +: 8]; // see [RULE4] [RULE13] [RULE17]
          timeout[i] = 1'b1; // see [RULE26]
          nxt_cur.reload_pend[i] = 1'b0;
        end else begin
          cnt_i = cnt_i - 8'h01; // see [RULE8]
        end
      end
      if (data_wr[i]) begin
        nxt_cur.data_q[8*i +: 8] = wd;
        if (mode[i] == MODE_STOP) begin
          cnt_i = wd; // see [RULE23]
        end else begin
          nxt_cur.reload_pend[i] = 1'b1;
        end
      end
      nxt_cur.count_q[8*i +: 8] = cnt_i;
      nxt_cur.pre_q[8*i +: 8] = pre_i;
      if (cur_ff.out_hold[i]) begin
        nxt_cur.out_q[i] = 1'b0;
      end else if (timeout[i]) begin
        nxt_cur.out_q[i] = ~cur_ff.out_q[i]; // see [RULE6]
      end
    end
    nxt_cur.out_hold = 4'h0;
    // Line channels: pulse mode flips the detector so the end of the pulse fires
    ch4_det = (mode[0][MODE_PULSE_BIT]) ? (pulse_mode[0] ? ~det_a : det_a) : det_4; // see [RULE9] [RULE12]
    ch3_det = (mode[1][MODE_PULSE_BIT]) ? (pulse_mode[1] ? ~det_b : det_b) : det_3; // see [RULE15]
    nxt_cur.det_4_prev = ch4_det;
    nxt_cur.det_3_prev = ch3_det;
    nxt_cur.det_a_prev = 1'b0;
    nxt_cur.det_b_prev = 1'b0;
    // Pending bits: timer A..D, line four, line three
    ev_in[3:0] = timeout; // see [RULE5]
    ev_in[4] = ch4_det && !cur_ff.det_4_prev; // see [RULE20] [RULE21] [RULE22]
    ev_in[5] = ch3_det && !cur_ff.det_3_prev;
    if (wr_fire && !cur_ff.w_err && cur_ff.aw_addr == ADDR_IRQ_PENDING && cur_ff.w_data[6] == 1'b0) begin
      nxt_cur.irq_pend = cur_ff.irq_pend & cur_ff.w_data[5:0];
    end
    // Set wins over clear; disabled channels drop pending
    nxt_cur.irq_pend = (nxt_cur.irq_pend | ev_in) & cur_ff.irq_en;
    if (wr_fire && !cur_ff.w_err) begin
      unique case (cur_ff.aw_addr)
        ADDR_EDGE_SELECT: nxt_cur.edge_select_ff = wd;
        ADDR_CTRL_A: begin
          nxt_cur.ctrl_a = wd[3:0];
          nxt_cur.out_hold[0] = wd[CTRL_RESET_OUT];
          nxt_cur.out_q[0] = wd[CTRL_RESET_OUT] ? 1'b0 : nxt_cur.out_q[0];
        end
        ADDR_CTRL_B: begin
          nxt_cur.ctrl_b = wd[3:0];
          nxt_cur.out_q[1] = wd[CTRL_RESET_OUT] ? 1'b0 : nxt_cur.out_q[1];
        end
        ADDR_CTRL_CD: begin
          nxt_cur.ctrl_c = wd[CD_C_LSB +: 3];
          nxt_cur.ctrl_d = wd[CD_D_LSB +: 3];
        end
        ADDR_IRQ_ENABLE: nxt_cur.irq_en = cur_ff.w_data[5:0];
        default: ;
      endcase
    end
    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_cur.aw_got = 1'b1;
      nxt_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_cur.w_got = 1'b1;
      nxt_cur.w_data = s_axi_wdata;
      nxt_cur.w_strb_bad = !s_axi_wstrb[0];
    end
    if (wr_fire) begin
      nxt_cur.wr_st = BUS_RESP;
      nxt_cur.aw_got = 1'b0;
      nxt_cur.w_got = 1'b0;
    end
    nxt_cur.w_err = !mapped(nxt_cur.aw_addr) || nxt_cur.w_strb_bad;
    if (cur_ff.wr_st == BUS_RESP && s_axi_bready) begin
      nxt_cur.wr_st = BUS_IDLE;
    end
    if (cur_ff.rd_st == BUS_IDLE && s_axi_arvalid) begin
      nxt_cur.rd_st = BUS_RESP;
      nxt_cur.r_err = !mapped(s_axi_araddr);
      unique case (s_axi_araddr)
        ADDR_EDGE_SELECT: nxt_cur.rdata = {24'h0, cur_ff.edge_select_ff};
        ADDR_CTRL_A:      nxt_cur.rdata = {28'h0, cur_ff.ctrl_a};
        ADDR_CTRL_B:      nxt_cur.rdata = {28'h0, cur_ff.ctrl_b};
        ADDR_CTRL_CD:     nxt_cur.rdata = {25'h0, cur_ff.ctrl_c, 1'b0, cur_ff.ctrl_d};
        ADDR_DATA_A:      nxt_cur.rdata = {24'h0, cur_ff.count_q[7:0]};
        ADDR_DATA_B:      nxt_cur.rdata = {24'h0, cur_ff.count_q[15:8]};
        ADDR_DATA_C:      nxt_cur.rdata = {24'h0, cur_ff.count_q[23:16]};
        ADDR_DATA_D:      nxt_cur.rdata = {24'h0, cur_ff.count_q[31:24]};
        ADDR_IRQ_ENABLE:  nxt_cur.rdata = {26'h0, cur_ff.irq_en};
        ADDR_IRQ_PENDING: nxt_cur.rdata = {26'h0, cur_ff.irq_pend};
        ADDR_OUT_STATUS:  nxt_cur.rdata = {28'h0, cur_ff.out_q};
        default:          nxt_cur.rdata = 32'h0;
      endcase
    end else if (cur_ff.rd_st == BUS_RESP && s_axi_rready) begin
      nxt_cur.rd_st = BUS_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ff <= '0;
      cur_ff.edge_select_ff <= RST_EDGE_SELECT;
      cur_ff.ctrl_a <= RST_CTRL;
      cur_ff.ctrl_b <= RST_CTRL;
      cur_ff.data_q <= {4{RST_DATA}};
      cur_ff.count_q <= {4{RST_DATA}};
      cur_ff.wr_st <= BUS_IDLE;
      cur_ff.rd_st <= BUS_IDLE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign s_axi_awready = !cur_ff.aw_got && (cur_ff.wr_st == BUS_IDLE);
  assign s_axi_wready  = !cur_ff.w_got && (cur_ff.wr_st == BUS_IDLE);
  assign s_axi_bvalid  = (cur_ff.wr_st == BUS_RESP);
  assign s_axi_bresp   = cur_ff.w_err ? RESP_SLVERR : RESP_OKAY;
  assign s_axi_arready = (cur_ff.rd_st == BUS_IDLE);
  assign s_axi_rvalid  = (cur_ff.rd_st == BUS_RESP);
  assign s_axi_rdata   = cur_ff.rdata;
  assign s_axi_rresp   = cur_ff.r_err ? RESP_SLVERR : RESP_OKAY;
  assign timer_a_output = cur_ff.out_q[0];
  assign timer_b_output = cur_ff.out_q[1];
  assign timer_c_output = cur_ff.out_q[2];
  assign timer_d_output = cur_ff.out_q[3];
  assign irq_pending_any = |cur_ff.irq_pend;

endmodule // multi_mode_timer_unit

// File: rtl/timer_unit_pkg.sv
package timer_unit_pkg;
  localparam logic [7:0]  IDX_EDGE_SELECT  = 8'h03;
  localparam logic [7:0]  ADDR_EDGE_SELECT = {IDX_EDGE_SELECT[5:0], 2'b00};
  localparam logic [7:0]  ADDR_CTRL_A      = 8'h20;
  localparam logic [7:0]  ADDR_CTRL_B      = 8'h24;
  localparam logic [7:0]  ADDR_CTRL_CD     = 8'h28;
  localparam logic [7:0]  ADDR_DATA_A      = 8'h30;
  localparam logic [7:0]  ADDR_DATA_B      = 8'h34;
  localparam logic [7:0]  ADDR_DATA_C      = 8'h38;
  localparam logic [7:0]  ADDR_DATA_D      = 8'h3c;
  localparam logic [7:0]  ADDR_IRQ_ENABLE  = 8'h40;
  localparam logic [7:0]  ADDR_IRQ_PENDING = 8'h44;
  localparam logic [7:0]  ADDR_OUT_STATUS  = 8'h48;
  localparam logic [7:0]  RST_EDGE_SELECT  = 8'h00;
  localparam logic [3:0]  RST_CTRL         = 4'h0;
  localparam logic [7:0]  RST_DATA         = 8'h00;
  localparam int          EDGE_BIT_A       = 4;
  localparam int          EDGE_BIT_B       = 3;
  localparam int          CTRL_RESET_OUT   = 4;
  localparam int          CD_C_LSB         = 4;
  localparam int          CD_D_LSB         = 0;
  localparam logic [3:0]  MODE_STOP        = 4'h0;
  localparam logic [3:0]  MODE_EVENT       = 4'h8;
  localparam int          MODE_PULSE_BIT   = 3;
  localparam logic [7:0]  PRE_DIV4         = 8'd4;
  localparam logic [7:0]  PRE_DIV10        = 8'd10;
  localparam logic [7:0]  PRE_DIV16        = 8'd16;
  localparam logic [7:0]  PRE_DIV50        = 8'd50;
  localparam logic [7:0]  PRE_DIV64        = 8'd64;
  localparam logic [7:0]  PRE_DIV100       = 8'd100;
  localparam logic [7:0]  PRE_DIV200       = 8'd200;
  localparam logic [7:0]  CNT_ONE          = 8'h01;
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_t;
endpackage

// File: verif/aux_source.sv
`timescale 1ns/10ps
module aux_source (
  output logic timer_clk,
  output logic aux_input_a,
  output logic aux_input_b,
  output int   tclk_count
);
  // Odd half period keeps rising timer edges off the system clock edges
  initial begin
    aux_input_a = 1'b0;
    aux_input_b = 1'b0;
    timer_clk = 1'b0;
    forever #25.3 timer_clk = ~timer_clk;
  end
  always @(posedge timer_clk) tclk_count <= tclk_count + 1;
  task automatic pulse_a(input int n);
    repeat (n) begin
      repeat (5) @(posedge timer_clk);
      aux_input_a <= 1'b1;
      repeat (5) @(posedge timer_clk);
      aux_input_a <= 1'b0;
    end
  endtask
  task automatic level_b(input logic v);
    @(posedge timer_clk);
    aux_input_b <= v;
  endtask
endmodule // aux_source

// File: verif/tb_multi_mode_timer_unit.sv
`timescale 1ns/10ps
module tb_multi_mode_timer_unit;
  import timer_unit_pkg::*;
  logic        aclk, aresetn, port_line_three, port_line_four, timer_clk, aux_input_a, aux_input_b;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, v;
  logic [3:0]  s_axi_wstrb, outs;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        timer_a_output, timer_b_output, timer_c_output, timer_d_output, irq_pending_any;
  int          tclk_count, num_errors, check_count, cycles, n;
  int          pre [8] = '{0, PRE_DIV4, PRE_DIV10, PRE_DIV16, PRE_DIV50, PRE_DIV64, PRE_DIV100, PRE_DIV200};
  assign outs = {timer_d_output, timer_c_output, timer_b_output, timer_a_output};
  multi_mode_timer_unit i_dut (.*);
  aux_source i_src (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic print_verdict();
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Longest run is the 256-count interval, about 20k cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wt(input int i, output int n);
    logic o;
    o = outs[i];
    do @(posedge aclk); while (outs[i] === o);
    n = tclk_count;
  endtask
  // First timeout after a mode change is not trusted, so two later ones are timed
  task automatic meas(input logic [7:0] ca, input int sh, input int c, input logic [7:0] da,
                      input logic [7:0] d, input int i);
    int n1;
    int n2;
    wr(ca, 32'h0, rs);
    wr(da, {24'h0, d}, rs);
    wr(ca, 32'(c) << sh, rs);
    wt(i, n1);
    wt(i, n1);
    wt(i, n2);
    chk("interval", pre[c] * (d == 8'h00 ? 256 : d), n2 - n1);
  endtask
  initial begin
    {aresetn, port_line_three, port_line_four, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'he3e0));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(ADDR_EDGE_SELECT, rd, rs);
    chk("edge reset", {24'h0, RST_EDGE_SELECT}, rd & 32'hff);
    rdr(8'h10, rd, rs);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rs});
    v = $urandom & 32'hff;
    wr(ADDR_EDGE_SELECT, v, rs);
    rdr(ADDR_EDGE_SELECT, rd, rs);
    chk("edge readback", v, rd & 32'hff);
    for (int c = 1; c < 8; c++) meas(ADDR_CTRL_CD, CD_D_LSB, c, ADDR_DATA_D, 8'h01, 3);
    meas(ADDR_CTRL_CD, CD_C_LSB, 1, ADDR_DATA_C, 8'h00, 2);
    meas(ADDR_CTRL_CD, CD_C_LSB, 2, ADDR_DATA_C, 8'(2 + $urandom % 4), 2);
    wr(ADDR_CTRL_CD, 32'h0, rs);
    wr(ADDR_EDGE_SELECT, 32'h18, rs);
    wr(ADDR_DATA_A, 32'h3, rs);
    wr(ADDR_CTRL_A, {28'h0, MODE_EVENT}, rs);
    wr(ADDR_IRQ_ENABLE, 32'h31, rs);
    i_src.pulse_a(2);
    rdr(ADDR_DATA_A, rd, rs);
    chk("event count", 32'h1, rd & 32'hff);
    chk("no timeout", 32'h0, {31'h0, timer_a_output});
    rdr(ADDR_IRQ_PENDING, rd, rs);
    chk("line irq", 32'h10, rd & 32'h31);
    i_src.pulse_a(1);
    rdr(ADDR_DATA_A, rd, rs);
    chk("reload", 32'h3, rd & 32'hff);
    chk("toggle", 32'h1, {31'h0, timer_a_output});
    rdr(ADDR_IRQ_PENDING, rd, rs);
    chk("timer irq", 32'h11, rd & 32'h31);
    chk("irq any", 32'h1, {31'h0, irq_pending_any});
    wr(ADDR_IRQ_ENABLE, 32'h20, rs);
    i_src.pulse_a(3);
    rdr(ADDR_IRQ_PENDING, rd, rs);
    chk("masked", 32'h0, rd & 32'h31);
    chk("toggle back", 32'h0, {31'h0, timer_a_output});
    wr(ADDR_DATA_B, 32'd200, rs);
    wr(ADDR_CTRL_B, 32'h9, rs);
    wr(ADDR_IRQ_PENDING, 32'h0, rs);
    repeat (100) @(posedge aclk);
    rdr(ADDR_DATA_B, rd, rs);
    chk("gated off", 32'd200, rd & 32'hff);
    i_src.level_b(1'b1);
    repeat (400) @(posedge aclk);
    rdr(ADDR_IRQ_PENDING, rd, rs);
    chk("no start irq", 32'h0, rd & 32'h31);
    i_src.level_b(1'b0);
    repeat (20) @(posedge aclk);
    rdr(ADDR_IRQ_PENDING, rd, rs);
    chk("pulse end irq", 32'h20, rd & 32'h31);
    rdr(ADDR_DATA_B, rd, rs);
    chk("measured", 32'h1, {31'h0, (8'd200 - rd[7:0]) inside {[8'd14:8'd17]}});
    wr(ADDR_DATA_B, 32'd200, rs);
    // Lines back on their own channels: four on falling edge, three on rising
    wr(ADDR_CTRL_A, 32'h0, rs);
    wr(ADDR_CTRL_B, 32'h0, rs);
    wr(ADDR_EDGE_SELECT, 32'h08, rs);
    wr(ADDR_IRQ_PENDING, 32'h0, rs);
    wr(ADDR_IRQ_ENABLE, 32'h30, rs);
    port_line_four <= 1'b1;
    repeat (10) @(posedge aclk);
    rdr(ADDR_IRQ_PENDING, rd, rs);
    chk("line rise ignored", 32'h0, rd & 32'h30);
    port_line_three <= 1'b1;
    port_line_four <= 1'b0;
    repeat (10) @(posedge aclk);
    rdr(ADDR_IRQ_PENDING, rd, rs);
    chk("line edges", 32'h30, rd & 32'h30);
    wr(ADDR_DATA_B, 32'h1, rs);
    wr(ADDR_CTRL_B, 32'h1, rs);
    wt(1, n);
    chk("b toggles", 32'h1, {31'h0, timer_b_output});
    wr(ADDR_CTRL_B, 32'h10, rs);
    chk("b forced low", 32'h0, {31'h0, timer_b_output});
    print_verdict();
  end
endmodule // tb_multi_mode_timer_unit

// File: verif/timer_unit_monitor.sv
`timescale 1ns/10ps
module timer_unit_monitor
  import timer_unit_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        timer_clk,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        timer_c_output,
  input wire logic        timer_d_output
);
  logic       tclk_ff;
  logic [3:0] since_ff;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Saturates so a stopped timer clock cannot wrap the count
  always_ff @(posedge aclk) begin
    tclk_ff <= timer_clk;
    if (timer_clk && !tclk_ff) since_ff <= 4'h0;
    else if (since_ff != 4'hf) since_ff <= since_ff + 4'h1;
  end
  bvalid_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped early");
  rvalid_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed early");
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  write_block_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  c_spacing_a:
    assert property ($changed(timer_c_output) |=> $stable(timer_c_output) [*8]) else $error("timer c toggles fast");
  d_spacing_a:
    assert property ($changed(timer_d_output) |=> $stable(timer_d_output) [*8]) else $error("timer d toggles fast");
  c_tclk_a:
    assert property ($changed(timer_c_output) |-> since_ff <= 4'h6) else $error("timer c not on timer clock");
  d_tclk_a:
    assert property ($changed(timer_d_output) |-> since_ff <= 4'h6) else $error("timer d not on timer clock");
endmodule // timer_unit_monitor
bind multi_mode_timer_unit timer_unit_monitor i_mon (.*);
